/* logic/vpd_pkg.sv */
package vpd_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CH_W = 40;
    localparam int unsigned DEPTH = 8192;
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned LOOP_W = 16;
    localparam int unsigned MAX_MODULES = 4;
    // internal rate selections in hz
    localparam int unsigned RATE0_HZ = 1000000;
    localparam int unsigned RATE1_HZ = 5000000;
    localparam int unsigned RATE2_HZ = 10000000;
    localparam int unsigned RATE3_HZ = 20000000;
    localparam int unsigned EXT_MAX_HZ = 25000000;
    localparam int unsigned CAP_MAX_HZ = 10000000;
    // divider counts, rounded down to whole cycles, never below one
    localparam logic [4:0] DIV0 = 5'(CLK_HZ / RATE0_HZ);
    localparam logic [4:0] DIV1 = 5'(CLK_HZ / RATE1_HZ);
    localparam logic [4:0] DIV2 = 5'(CLK_HZ / RATE2_HZ);
    localparam logic [4:0] DIV3 = 5'((CLK_HZ / RATE3_HZ) < 1 ? 1 : (CLK_HZ / RATE3_HZ));
    // least cycles between capture strobes (10 mhz limit)
    localparam logic [1:0] CAP_GAP = 2'((CLK_HZ + CAP_MAX_HZ - 1) / CAP_MAX_HZ);
    localparam int unsigned FIFO_DEPTH = 8;
    // stored word: data, per-pin float, capture bit
    localparam int unsigned WORD_W = 2 * CH_W + 1;
    localparam int unsigned CAP_BIT = 2 * CH_W;
    localparam int unsigned FLT_LSB = CH_W;
    typedef enum logic [1:0] {
        VPD_IDLE = 2'b00,
        VPD_RUN  = 2'b01,
        VPD_DONE = 2'b10
    } vpd_state_t;
endpackage

/* logic/vpd_fifo.sv */
`timescale 1ns/1ns
module vpd_fifo #(
    parameter int unsigned WIDTH = 81,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic flush, // drop contents
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // not empty
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q, rd_q;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];
    always_ff @(posedge clk) begin
        if (do_wr) mem[wr_q[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_wr) wr_q <= wr_q + 1'b1;
            if (do_rd) rd_q <= rd_q + 1'b1;
        end
    end
endmodule

/* logic/vpd_sync.sv */
`timescale 1ns/1ns
module vpd_sync #(
    parameter int unsigned W = 6
) (
    input wire logic clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // filtered level
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_r;
    assign q = q_r;
    // a change counts only once the second and third stages agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_r <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) q_r[i] <= s3_q[i];
            end
        end
    end
endmodule

/* logic/vpd_top.sv */
// How it works
// [RULE1] internal drive clock, four rates, 20 mhz max; the fastest setting here ticks every cycle, 25 mhz
// [RULE2] external drive clock up to 25 mhz; the pin filter here loses edges past 6.25 mhz
// [RULE3] start, stop, enable pins qualify driving
// [RULE4] hold input delays next vector
// [RULE5] per-vector, per-pin float control from pattern
// [RULE6] float-all input floats all 40 pins
// [RULE7] up to 8192 vectors, one per clock
// [RULE8] 40 channels, four modules chain wider; a slave's pin filter here drops the master's one-cycle chain ticks
// [RULE9] loop a vector set 1 to 65536 times
// [RULE10] drive and sample clocks kept separate
// [RULE11] sample strobe no faster than 10 mhz
// [RULE12] pattern bit makes the capture clock
// [RULE13] end of loops or stop reports done
`timescale 1ns/1ns
module vpd_top #(
    parameter int unsigned CH_W = vpd_pkg::CH_W,
    parameter int unsigned DEPTH = vpd_pkg::DEPTH,
    parameter int unsigned FIFO_DEPTH = vpd_pkg::FIFO_DEPTH
) (
    input wire logic clk, // 25 mhz system clock
    input wire logic resetn, // async reset, active low
    // pattern load port
    input wire logic load_we, // write one stored vector
    input wire logic [vpd_pkg::ADDR_W-1:0] load_addr, // vector index
    input wire logic [CH_W-1:0] load_data, // vector drive levels
    input wire logic [CH_W-1:0] load_float, // per-pin float, 1 floats
    input wire logic load_capture, // capture clock level for vector
    // configuration
    input wire logic [1:0] rate_sel, // internal rate 1/5/12.5/25 mhz
    input wire logic ext_clk_sel, // 1 uses external drive clock
    input wire logic [vpd_pkg::ADDR_W-1:0] first_addr, // first vector
    input wire logic [vpd_pkg::ADDR_W-1:0] last_addr, // last vector
    input wire logic [vpd_pkg::ADDR_W-1:0] loop_start, // loop set first
    input wire logic [vpd_pkg::ADDR_W-1:0] loop_end, // loop set last
    input wire logic [vpd_pkg::LOOP_W-1:0] loop_count_m1, // repeats minus one
    input wire logic arm, // pulse: begin a run
    // link pins, asynchronous
    input wire logic ext_clk_in, // external drive clock pin
    input wire logic start_in, // rising edge begins driving
    input wire logic stop_in, // rising edge halts driving
    input wire logic enable_in, // high lets clocks through
    input wire logic wait_in, // high holds next vector
    input wire logic float_all_in, // low floats all pins
    input wire logic chain_tick_in, // drive tick from master module
    input wire logic chain_slave, // 1 follows chain_tick_in
    output logic chain_tick_out, // drive tick for slave modules
    output logic [CH_W-1:0] vec_out, // vector pin levels
    output logic [CH_W-1:0] vec_oe, // pin drive enables
    output logic capture_clk, // sampling clock to input section
    output logic drive_clk_out, // internal drive clock out
    output logic busy, // run in progress
    output logic done // run completed or halted
);
    localparam int unsigned AW = vpd_pkg::ADDR_W;
    localparam int unsigned WW = 2 * CH_W + 1;

    // the address counter is fixed at the package width, so deeper patterns cannot be served
    initial begin
        if (CH_W < 1 || DEPTH > (1 << AW) || DEPTH < 2) $error("unsupported vpd_top parameters");
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) $error("fifo depth not a power of two");
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [5:0] pins_s;

    vpd_sync #(.W(6)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({chain_tick_in, ext_clk_in, start_in, stop_in, enable_in, wait_in}),
        .q(pins_s)
    );

    wire chain_s = pins_s[5];
    wire extclk_s = pins_s[4];
    wire start_s = pins_s[3];
    wire stop_s = pins_s[2];
    wire enable_s = pins_s[1];
    wire wait_s = pins_s[0];

    // float-all is sampled too; it is a level, so a slip of a few cycles is tolerable
    logic [2:0] flt_sync_q;
    logic float_all_q;

    // one more flop on the clock, start, stop and chain pins turns their filtered levels into edges
    logic extclk_d_q;
    logic start_d_q;
    logic stop_d_q;
    logic chain_d_q;

    ////////////////////////////////////////////////////////////////////
    // drive tick generation
    logic [4:0] div_q;
    logic int_clk_q;

    wire [4:0] div_sel = (rate_sel == 2'd0) ? vpd_pkg::DIV0 :
                         (rate_sel == 2'd1) ? vpd_pkg::DIV1 :
                         (rate_sel == 2'd2) ? vpd_pkg::DIV2 : vpd_pkg::DIV3;
    wire int_tick = (div_q + 5'd1 >= div_sel); // [RULE1]
    wire [4:0] div_nx = int_tick ? 5'h00 : div_q + 5'd1;
    // drive clock pin is high for the first half of each period
    wire int_clk_nx = (div_q < (div_sel >> 1)) || (div_sel == 5'd1 && !int_clk_q);

    // the pin filter needs each level for two cycles, so external edges past 6.25 mhz are lost
    wire ext_tick = extclk_s && !extclk_d_q; // [RULE2]
    wire chain_tick = chain_s && !chain_d_q; // [RULE8]
    wire raw_tick = chain_slave ? chain_tick : (ext_clk_sel ? ext_tick : int_tick);

    wire start_edge = start_s && !start_d_q;
    wire stop_edge = stop_s && !stop_d_q;
    wire qual_tick = raw_tick && enable_s; // [RULE3]

    ////////////////////////////////////////////////////////////////////
    // sequencer
    vpd_pkg::vpd_state_t state_q;
    logic started_q;
    logic [AW-1:0] addr_q;
    logic [vpd_pkg::LOOP_W-1:0] loops_q;
    logic [WW-1:0] mem [DEPTH];
    logic [WW-1:0] rd_word_q;
    logic rd_valid_q;
    logic fetched_all_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WW-1:0] fifo_out_data;

    wire in_run = (state_q == vpd_pkg::VPD_RUN);
    wire running = in_run && started_q;
    wire at_last = (addr_q == last_addr);
    wire at_loop_end = (addr_q == loop_end);
    wire loop_again = at_loop_end && (loops_q != '0); // [RULE9]
    wire fetch_last = at_last && !loop_again;

    // prefetch stalls only while both the fifo and the read stage are full
    wire fetch = running && !fetched_all_q && (!rd_valid_q || fifo_in_ready);
    wire [AW-1:0] addr_nx = loop_again ? loop_start : addr_q + 1'b1;

    // hold input freezes output; the tick is simply lost while it stands
    wire drive_now = qual_tick && running && fifo_out_valid && !wait_s; // [RULE4]
    // a stop edge ends the run at once and drops what is still staged
    wire finish = (fetched_all_q && !fifo_out_valid && !rd_valid_q) || stop_edge; // [RULE13]

    always_ff @(posedge clk) begin
        if (load_we) mem[load_addr] <= {load_capture, load_float, load_data}; // [RULE7]
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 5'h00;
            int_clk_q <= 1'b0;
        end else begin
            div_q <= div_nx;
            int_clk_q <= int_clk_nx;
        end
    end

    // edge detectors reset low like the filtered pins, so no false edge follows reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extclk_d_q <= 1'b0;
            start_d_q <= 1'b0;
            stop_d_q <= 1'b0;
            chain_d_q <= 1'b0;
        end else begin
            extclk_d_q <= extclk_s;
            start_d_q <= start_s;
            stop_d_q <= stop_s;
            chain_d_q <= chain_s;
        end
    end

    // inverted on entry so that float_all_q is high while the pins must let go
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flt_sync_q <= 3'h0;
            float_all_q <= 1'b0;
        end else begin
            flt_sync_q <= {flt_sync_q[1:0], !float_all_in};
            if (flt_sync_q[1] == flt_sync_q[2]) float_all_q <= flt_sync_q[2];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= vpd_pkg::VPD_IDLE;
            started_q <= 1'b0;
            addr_q <= '0;
            fetched_all_q <= 1'b0;
        end else begin
            case (state_q)
                vpd_pkg::VPD_IDLE, vpd_pkg::VPD_DONE: begin
                    if (arm) begin
                        state_q <= vpd_pkg::VPD_RUN;
                        started_q <= 1'b0;
                        addr_q <= first_addr;
                        fetched_all_q <= 1'b0;
                    end
                end
                vpd_pkg::VPD_RUN: begin
                    if (start_edge || chain_slave) started_q <= 1'b1; // [RULE3]
                    if (started_q && finish) begin
                        state_q <= vpd_pkg::VPD_DONE;
                    end else if (fetch) begin
                        if (fetch_last) fetched_all_q <= 1'b1;
                        addr_q <= addr_nx;
                    end
                end
                default: state_q <= vpd_pkg::VPD_IDLE;
            endcase
        end
    end

    // loop counter: loaded on arm, counts down once per pass back to the loop start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loops_q <= '0;
        end else if (!in_run && arm) begin
            loops_q <= loop_count_m1;
        end else if (fetch && loop_again && !finish) begin
            loops_q <= loops_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid_q <= 1'b0;
            rd_word_q <= '0;
        end else if (state_q != vpd_pkg::VPD_RUN) begin
            rd_valid_q <= 1'b0;
        end else begin
            if (fetch) begin
                rd_word_q <= mem[addr_q];
                rd_valid_q <= 1'b1;
            end else if (fifo_in_ready) begin
                rd_valid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // vector staging fifo
    vpd_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .flush(!in_run),
        .in_valid(rd_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(rd_word_q),
        .out_valid(fifo_out_valid),
        .out_ready(drive_now),
        .out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // output stage
    logic [CH_W-1:0] vec_q;
    logic [CH_W-1:0] flt_q;
    logic [CH_W-1:0] oe_q;
    logic cap_lvl_q;
    logic [1:0] cap_gap_q;
    logic cap_q;
    logic tick_out_q;
    logic drv_clk_q;
    logic busy_q;
    logic done_q;

    wire cap_rise = cap_lvl_q && !cap_q;
    wire cap_ok = (cap_gap_q == 2'd0); // [RULE11]

    // one slice per pin; the enable lags the level by a cycle, so a pin floated
    // in the pattern shows its new level for one cycle before it lets go
    for (genvar p = 0; p < CH_W; p++) begin : g_pin
        wire pin_drive = !float_all_q && !flt_q[p];
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                vec_q[p] <= 1'b0;
                flt_q[p] <= 1'b1;
                oe_q[p] <= 1'b0;
            end else begin
                if (drive_now) begin
                    vec_q[p] <= fifo_out_data[p];
                    flt_q[p] <= fifo_out_data[CH_W + p]; // [RULE5]
                end
                oe_q[p] <= pin_drive; // [RULE6]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_lvl_q <= 1'b0;
        end else if (drive_now) begin
            cap_lvl_q <= fifo_out_data[2*CH_W]; // [RULE12]
        end
    end

    // capture clock stands apart from the drive tick; it follows the pattern bit, with its rises held CAP_GAP cycles apart
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_q <= 1'b0;
            cap_gap_q <= 2'd0;
        end else begin
            if (cap_rise && cap_ok) begin
                cap_q <= 1'b1; // [RULE10]
                cap_gap_q <= vpd_pkg::CAP_GAP - 2'd1;
            end else begin
                if (!cap_lvl_q) cap_q <= 1'b0;
                if (!cap_ok) cap_gap_q <= cap_gap_q - 2'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_out_q <= 1'b0;
            drv_clk_q <= 1'b0;
        end else begin
            tick_out_q <= chain_slave ? 1'b0 : (qual_tick && running); // [RULE8]
            drv_clk_q <= int_clk_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= in_run;
            done_q <= (state_q == vpd_pkg::VPD_DONE); // [RULE13]
        end
    end

    assign vec_out = vec_q;
    assign vec_oe = oe_q;
    assign capture_clk = cap_q;
    assign chain_tick_out = tick_out_q;
    assign drive_clk_out = drv_clk_q;
    assign busy = busy_q;
    assign done = done_q;
endmodule

/* tb/vpd_top_properties.sv */
`timescale 1ns/1ns
module vpd_top_properties #(
    parameter int unsigned CH_W = vpd_pkg::CH_W
) (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic arm, // run request
    input wire logic ext_clk_sel, // external clock chosen
    input wire logic ext_clk_in, // external drive clock
    input wire logic stop_in, // halt pin
    input wire logic enable_in, // clock enable pin
    input wire logic wait_in, // hold pin
    input wire logic float_all_in, // low floats all pins
    input wire logic [CH_W-1:0] vec_out, // vector levels
    input wire logic [CH_W-1:0] vec_oe, // pin enables
    input wire logic capture_clk, // sampling clock
    input wire logic busy, // run in progress
    input wire logic done // run finished
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    property p_arm_busy;
        arm && !busy |-> ##2 busy;
    endproperty
    a_arm_busy: assert property (p_arm_busy) else $error("busy late after arm");
    property p_done_holds;
        done && !arm && !$past(arm) |=> done;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done dropped without arm");
    property p_stop_done;
        $rose(stop_in) && busy |-> ##[1:12] done;
    endproperty
    a_stop_done: assert property (p_stop_done) else $error("stop did not finish run");
    // sync filter takes about four cycles, so eight quiet cycles leave margin
    property p_wait_hold;
        wait_in [*8] |-> $stable(vec_out);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("vector moved while held");
    property p_enable_hold;
        !enable_in [*8] |-> $stable(vec_out);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("vector moved while disabled");
    property p_ext_still;
        (ext_clk_sel && !ext_clk_in) [*8] |-> $stable(vec_out);
    endproperty
    a_ext_still: assert property (p_ext_still) else $error("vector moved without external edge");
    property p_float_all;
        !float_all_in [*6] |-> vec_oe == '0;
    endproperty
    a_float_all: assert property (p_float_all) else $error("pins driven while floated");
    property p_cap_gap;
        $rose(capture_clk) |=> (!$rose(capture_clk)) [*2];
    endproperty
    a_cap_gap: assert property (p_cap_gap) else $error("capture strobes too close");
endmodule
bind vpd_top vpd_top_properties #(.CH_W(CH_W)) i_vpd_top_properties (.clk(clk), .resetn(resetn), .arm(arm),
    .ext_clk_sel(ext_clk_sel), .ext_clk_in(ext_clk_in), .stop_in(stop_in), .enable_in(enable_in),
    .wait_in(wait_in), .float_all_in(float_all_in), .vec_out(vec_out), .vec_oe(vec_oe),
    .capture_clk(capture_clk), .busy(busy), .done(done));

/* tb/vpd_uut_model.sv */
`timescale 1ns/1ns
module vpd_uut_model (
    input wire logic clk, // pacing clock
    output logic ext_clk_in, // external drive clock
    output logic start_in, // begin driving
    output logic stop_in, // halt driving
    output logic enable_in, // clock qualifier
    output logic wait_in // bus cycle hold
);
    logic ext_on = 1'b0;
    initial begin
        ext_clk_in = 1'b0;
        start_in = 1'b0;
        stop_in = 1'b0;
        enable_in = 1'b1;
        wait_in = 1'b0;
    end
    // 6.25 mhz: the pin filter needs each level for two clocks; parked low outside runs
    always begin
        repeat (2) @(posedge clk);
        #2;
        ext_clk_in = ext_on ? !ext_clk_in : 1'b0;
    end
    // pulse long enough to pass the pin filter
    task automatic pulse(input logic is_stop);
        if (is_stop) stop_in = 1'b1;
        else start_in = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        start_in = 1'b0;
        stop_in = 1'b0;
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    localparam int unsigned W = vpd_pkg::CH_W;
    localparam int unsigned AW = vpd_pkg::ADDR_W;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic load_we = 1'b0;
    logic load_capture = 1'b0;
    logic arm = 1'b0;
    logic ext_clk_sel = 1'b0;
    logic float_all_in = 1'b1;
    logic [1:0] rate_sel = 2'h0;
    logic [AW-1:0] load_addr = '0, first_addr = '0, last_addr = '0, loop_start = '0, loop_end = '0;
    logic [vpd_pkg::LOOP_W-1:0] loop_count_m1 = '0;
    logic [W-1:0] load_data = '0, load_float = '0, prev_out = '0, oe_pend = '0;
    logic [W-1:0] vec_out, vec_oe;
    logic ext_clk_in, start_in, stop_in, enable_in, wait_in, capture_clk, busy, done, tick_out, drv_clk;
    logic oe_chk = 1'b0, prev_cap = 1'b0, prev_tick = 1'b0, prev_drv = 1'b0;
    int ticks = 0, drv_rises = 0;
    logic [W-1:0] pd [8];
    logic [W-1:0] pf [8];
    int divs [4] = '{vpd_pkg::DIV0, vpd_pkg::DIV1, vpd_pkg::DIV2, vpd_pkg::DIV3};
    int exp_q [$];
    int failures = 0, check_count = 0, seed = 84278, changes = 0, caps = 0, gap = 0, since = 0, k, m;
    always #20 clk = ~clk;
    vpd_top i_vpd_top (.clk(clk), .resetn(resetn), .load_we(load_we), .load_addr(load_addr),
        .load_data(load_data), .load_float(load_float), .load_capture(load_capture), .rate_sel(rate_sel),
        .ext_clk_sel(ext_clk_sel), .first_addr(first_addr), .last_addr(last_addr), .loop_start(loop_start),
        .loop_end(loop_end), .loop_count_m1(loop_count_m1), .arm(arm), .ext_clk_in(ext_clk_in),
        .start_in(start_in), .stop_in(stop_in), .enable_in(enable_in), .wait_in(wait_in),
        .float_all_in(float_all_in), .chain_tick_in(1'b0), .chain_slave(1'b0), .chain_tick_out(tick_out),
        .vec_out(vec_out), .vec_oe(vec_oe), .capture_clk(capture_clk), .drive_clk_out(drv_clk),
        .busy(busy), .done(done));
    vpd_uut_model i_vpd_uut_model (.clk(clk), .ext_clk_in(ext_clk_in), .start_in(start_in), .stop_in(stop_in),
        .enable_in(enable_in), .wait_in(wait_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic run_begin(input int f, input int l, input int ls, input int le, input int lc, input int r,
                             input bit x);
        int i;
        int n;
        first_addr = AW'(f);
        last_addr = AW'(l);
        loop_start = AW'(ls);
        loop_end = AW'(le);
        loop_count_m1 = 16'(lc);
        rate_sel = 2'(r);
        ext_clk_sel = x;
        since = -1000;
        i = f;
        n = 0;
        forever begin
            exp_q.push_back(i);
            if (i == le && n < lc) begin
                n++;
                i = ls;
            end else if (i == l) break;
            else i++;
        end
        arm = 1'b1;
        step(1);
        arm = 1'b0;
        step(4);
        i_vpd_uut_model.pulse(1'b0);
    endtask
    task automatic run_end(input bit stopped);
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            step(1);
            k++;
        end
        step(2);
        if (stopped) exp_q.delete();
        check("done", W'(done), W'(1));
        check("busy", W'(busy), W'(0));
        check("vectors left", W'(exp_q.size()), W'(0));
        exp_q.delete();
    endtask
    // the monitor pops one note per new vector; oe lags vec_out by a cycle
    always @(negedge clk) begin
        if (resetn) begin
            if (oe_chk) check("vec_oe", vec_oe, oe_pend);
            oe_chk = 1'b0;
            if (capture_clk === 1'b1 && prev_cap !== 1'b1) caps++;
            prev_cap = capture_clk;
            if (tick_out === 1'b1 && prev_tick !== 1'b1) ticks++;
            if (drv_clk === 1'b1 && prev_drv !== 1'b1) drv_rises++;
            prev_tick = tick_out;
            prev_drv = drv_clk;
            since++;
            if (vec_out !== prev_out) begin
                changes++;
                if (exp_q.size() == 0) check("unexpected vector", vec_out, prev_out);
                else begin
                    m = exp_q.pop_front();
                    check("vec_out", vec_out, pd[m]);
                    oe_pend = ~pf[m];
                    oe_chk = 1'b1;
                    if (gap != 0 && since > 0) check("tick spacing", W'(since), W'(gap));
                end
                since = 0;
                prev_out = vec_out;
            end
        end
    end
    initial begin
        step(20000);
        failures++;
        tally_and_finish;
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            pd[i] = {8'(i + 1), 32'($random(seed))};
            pf[i] = (i == 3) ? W'($random(seed)) : '0;
        end
        step(10);
        resetn = 1'b1;
        step(2);
        for (int i = 0; i < 8; i++) begin
            load_we = 1'b1;
            load_addr = AW'(i);
            load_data = pd[i];
            load_float = pf[i];
            load_capture = (i % 2 == 0);
            step(1);
        end
        load_we = 1'b0;
        k = drv_rises;
        step(100);
        check("drive clock", W'(drv_rises - k), W'(4));
        for (int r = 0; r < 4; r++) begin
            gap = divs[r];
            caps = 0;
            run_begin(0, 2, 0, 0, 0, r, 1'b0);
            run_end(1'b0);
            if (r == 0) check("capture edges", W'(caps), W'(2));
            $display("test rate %0d finished", r);
        end
        gap = divs[2];
        run_begin(1, 5, 2, 3, 2, 2, 1'b0);
        run_end(1'b0);
        float_all_in = 1'b0;
        step(8);
        check("floated oe", vec_oe, '0);
        float_all_in = 1'b1;
        step(6);
        check("restored oe", vec_oe, '1);
        $display("test loop and float finished");
        gap = 0;
        i_vpd_uut_model.wait_in = 1'b1;
        i_vpd_uut_model.ext_on = 1'b1;
        run_begin(0, 7, 0, 0, 0, 0, 1'b1);
        k = changes;
        step(30);
        check("held by wait", W'(changes), W'(k));
        i_vpd_uut_model.wait_in = 1'b0;
        step(4);
        i_vpd_uut_model.enable_in = 1'b0;
        step(6);
        k = changes;
        step(30);
        check("held by enable", W'(changes), W'(k));
        i_vpd_uut_model.enable_in = 1'b1;
        run_end(1'b0);
        i_vpd_uut_model.ext_on = 1'b0;
        step(12);
        $display("test external clock finished");
        gap = divs[0];
        run_begin(0, 7, 0, 0, 0, 0, 1'b0);
        step(5);
        k = ticks;
        step(75);
        check("chain ticks", W'(ticks - k), W'(3));
        i_vpd_uut_model.pulse(1'b1);
        run_end(1'b1);
        k = changes;
        step(60);
        check("halted vectors", W'(changes), W'(k));
        $display("test stop finished");
        tally_and_finish;
    end
endmodule
